// ---- design/moist_measure_ctrl.sv ----
// Purpose: Moisture resistive measurement control with APB registers.
// Assumes: The ADC front end runs on clk_sys_i and pulses adc_valid_i per sample.
// Notes: APB answers with no wait states; irq_o is a level.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module moist_measure_ctrl (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic adc_valid_i,
   input wire logic [7:0] adc_data_i,
   output logic sample_req_o,
   output logic [1:0] pullup_sel_o,
   output logic [5:0] shift_factor_o,
   output logic irq_o
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_r, rst_n;

   // Release is synchronised so no flop leaves reset on a different edge.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_REQ = 3'b001,
      ST_WAIT = 3'b010,
      ST_EVAL = 3'b011
   } state_t;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [3:0] gnd_r, gnd_nxt;
   logic [2:0] retry_lim_r, retry_lim_nxt;
   logic [5:0] shift_r, shift_nxt;
   logic [2:0] avg_code_r, avg_code_nxt;
   logic [5:0] noise_r, noise_nxt;
   logic [1:0] target_r, target_nxt;
   logic [7:0] thresh_r, thresh_nxt;
   logic manual_r, manual_nxt;
   logic [2:0] st_r, st_nxt, mask_r, mask_nxt, events;
   logic pready_r, pready_nxt, slverr_r, slverr_nxt, irq_r, irq_nxt;
   logic [31:0] prdata_r, prdata_nxt, rd_data;
   logic [9:0] idx;
   logic hit, acc_en, wr_en, done_w;
   moist_pkg::result_t result_r, result_nxt;
   logic [7:0] final_avg_r, final_avg_nxt;
   state_t state_r, state_nxt;

   assign idx = paddr_i[11:2];
   assign acc_en = psel_i && penable_i && pready_r;
   assign wr_en = acc_en && pwrite_i && hit;

   // Read decode; unmapped addresses read zero with an error, unaligned ones read the register with an error.
   always_comb
   begin
      rd_data = '0;
      hit = (paddr_i[1:0] == 2'b00);
      case (idx)
         moist_pkg::IDX_GND_RETRY: rd_data[6:0] = {gnd_r, retry_lim_r};
         moist_pkg::IDX_SHIFT: rd_data[5:0] = shift_r;
         moist_pkg::IDX_AVG_CODE: rd_data[2:0] = avg_code_r;
         moist_pkg::IDX_NOISE: rd_data[5:0] = noise_r;
         moist_pkg::IDX_TARGET: rd_data[1:0] = target_r;
         moist_pkg::IDX_THRESH: rd_data[7:0] = thresh_r;
         moist_pkg::IDX_MANUAL: rd_data[moist_pkg::MANUAL_BIT] = manual_r;
         moist_pkg::IDX_FINAL_AVG: rd_data[7:0] = final_avg_r;
         moist_pkg::IDX_RESULT:
         begin
            rd_data[2:0] = result_r;
            rd_data[moist_pkg::BUSY_BIT] = (state_r != ST_IDLE);
         end
         moist_pkg::IDX_IRQ_STATUS: rd_data[2:0] = st_r;
         moist_pkg::IDX_IRQ_MASK: rd_data[2:0] = mask_r;
         default: hit = 1'b0;
      endcase
   end

   // Next values of the software registers and the bus answer.
   always_comb
   begin
      gnd_nxt = gnd_r;
      retry_lim_nxt = retry_lim_r;
      shift_nxt = shift_r;
      avg_code_nxt = avg_code_r;
      noise_nxt = noise_r;
      target_nxt = target_r;
      thresh_nxt = thresh_r;
      mask_nxt = mask_r;
      manual_nxt = manual_r;
      pready_nxt = psel_i && !penable_i;
      prdata_nxt = (psel_i && !penable_i) ? rd_data : prdata_r;
      slverr_nxt = (psel_i && !penable_i) ? !hit : slverr_r;
      // The device clears the request at the end of a detection.
      if (done_w)
      begin
         manual_nxt = 1'b0;
      end
      if (wr_en)
      begin
         case (idx)
            moist_pkg::IDX_GND_RETRY:
            begin
               gnd_nxt = pwdata_i[6:3];
               retry_lim_nxt = pwdata_i[2:0];
            end
            moist_pkg::IDX_SHIFT: shift_nxt = pwdata_i[5:0];
            moist_pkg::IDX_AVG_CODE: avg_code_nxt = pwdata_i[2:0];
            moist_pkg::IDX_NOISE: noise_nxt = pwdata_i[5:0];
            moist_pkg::IDX_TARGET: target_nxt = pwdata_i[1:0];
            moist_pkg::IDX_THRESH: thresh_nxt = pwdata_i[7:0];
            moist_pkg::IDX_IRQ_MASK: mask_nxt = pwdata_i[2:0];
            moist_pkg::IDX_MANUAL:
            begin
               // A write of one wins over the clear in the same cycle.
               if (pwdata_i[moist_pkg::MANUAL_BIT])
               begin
                  manual_nxt = 1'b1;
               end
            end
            default: manual_nxt = manual_nxt;
         endcase
      end
      // Events set sticky bits after the write-one clear, so they win.
      st_nxt = st_r;
      if (wr_en && (idx == moist_pkg::IDX_IRQ_STATUS))
      begin
         st_nxt = st_r & ~pwdata_i[2:0];
      end
      st_nxt = st_nxt | events;
      irq_nxt = |(st_r & mask_r);
   end

   // Registers only.
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gnd_r <= moist_pkg::RST_GROUND;
         retry_lim_r <= moist_pkg::RST_RETRY;
         shift_r <= moist_pkg::RST_SHIFT;
         avg_code_r <= moist_pkg::RST_AVG_CODE;
         noise_r <= moist_pkg::RST_NOISE;
         target_r <= moist_pkg::RST_TARGET;
         thresh_r <= moist_pkg::RST_THRESH;
         mask_r <= '0;
         st_r <= '0;
         manual_r <= 1'b0;
         pready_r <= 1'b0;
         prdata_r <= '0;
         slverr_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         gnd_r <= gnd_nxt;
         retry_lim_r <= retry_lim_nxt;
         shift_r <= shift_nxt;
         avg_code_r <= avg_code_nxt;
         noise_r <= noise_nxt;
         target_r <= target_nxt;
         thresh_r <= thresh_nxt;
         mask_r <= mask_nxt;
         st_r <= st_nxt;
         manual_r <= manual_nxt;
         pready_r <= pready_nxt;
         prdata_r <= prdata_nxt;
         slverr_r <= slverr_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Measurement sequencer
   // ----------------------------------------------------------------
   logic [14:0] acc_sum;
   logic [7:0] acc_max, acc_cnt, n_samples, avg_w;
   logic acc_clear, clip_w, retry_cond, open_w, req_r, req_nxt;
   logic [2:0] retries_r, retries_nxt;

   sample_accumulator #(
      .DATA_W(8),
      .CNT_W(8),
      .SUM_W(15)
   ) u_acc (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .clear_i(acc_clear),
      .valid_i(adc_valid_i && (state_r == ST_WAIT)),
      .data_i(adc_data_i),
      .sum_o(acc_sum),
      .max_o(acc_max),
      .count_o(acc_cnt)
   );

   // Two to the code samples form one reading.
   assign n_samples = 8'(9'h001 << avg_code_r);
   assign avg_w = 8'(acc_sum >> avg_code_r);
   // Clipped at full scale; at lowest current only when the average is low.
   assign clip_w = (acc_max == moist_pkg::FULL_SCALE);
   assign open_w = avg_w >= (moist_pkg::FULL_SCALE - {2'b00, noise_r});
   assign retry_cond = clip_w && ((target_r != moist_pkg::CUR_LOWEST) || !open_w);
   assign done_w = (state_r == ST_EVAL) && (state_nxt == ST_IDLE);

   // Sequencer next state, classification and event pulses.
   always_comb
   begin
      state_nxt = state_r;
      retries_nxt = retries_r;
      result_nxt = result_r;
      final_avg_nxt = final_avg_r;
      req_nxt = 1'b0;
      acc_clear = 1'b0;
      events = '0;
      case (state_r)
         ST_IDLE:
         begin
            acc_clear = 1'b1;
            if (manual_r)
            begin
               retries_nxt = '0;
               state_nxt = ST_REQ;
            end
         end
         ST_REQ:
         begin
            req_nxt = 1'b1;
            state_nxt = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (adc_valid_i)
            begin
               state_nxt = (acc_cnt == n_samples - 8'h01) ? ST_EVAL : ST_REQ;
            end
         end
         ST_EVAL:
         begin
            state_nxt = ST_IDLE;
            events[moist_pkg::IRQ_DONE] = 1'b1;
            if (retry_cond && (retries_r < retry_lim_r))
            begin
               // Measure again rather than accept a clipped reading.
               acc_clear = 1'b1;
               retries_nxt = retries_r + 3'h1;
               events = '0;
               state_nxt = ST_REQ;
            end
            else if (retry_cond)
            begin
               result_nxt = moist_pkg::RES_ABORT;
               final_avg_nxt = moist_pkg::ZERO_SCALE;
               events[moist_pkg::IRQ_ABORT] = 1'b1;
            end
            else if (clip_w)
            begin
               result_nxt = moist_pkg::RES_OPEN;
               final_avg_nxt = moist_pkg::FULL_SCALE;
            end
            else if (avg_w <= {4'h0, gnd_r})
            begin
               result_nxt = moist_pkg::RES_GROUND;
               final_avg_nxt = moist_pkg::ZERO_SCALE;
            end
            else if (avg_w < thresh_r)
            begin
               result_nxt = moist_pkg::RES_MOIST;
               final_avg_nxt = avg_w;
               events[moist_pkg::IRQ_MOIST] = 1'b1;
            end
            else
            begin
               result_nxt = moist_pkg::RES_DRY;
               final_avg_nxt = avg_w;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Registers only.
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         retries_r <= '0;
         result_r <= moist_pkg::RES_NONE;
         final_avg_r <= moist_pkg::ZERO_SCALE;
         req_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         retries_r <= retries_nxt;
         result_r <= result_nxt;
         final_avg_r <= final_avg_nxt;
         req_r <= req_nxt;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = slverr_r;
   assign irq_o = irq_r;
   assign sample_req_o = req_r;
   assign pullup_sel_o = target_r;
   assign shift_factor_o = shift_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence
   sequence s_eval_retry;
      state_r == ST_EVAL && retry_cond && retries_r < retry_lim_r;
   endsequence

   a_apb_answer: assert property (s_setup |=> s_answer)
      else $error("APB answer not one cycle after setup.");
   a_retry_on_clip: assert property (s_eval_retry |=> state_r == ST_REQ ##1 sample_req_o)
      else $error("Clipped reading was not measured again.");
   a_retry_cond: assert property (state_r == ST_EVAL && clip_w && target_r != 2'h0 |=> state_r == ST_REQ || result_r == moist_pkg::RES_ABORT)
      else $error("Clip at higher current gave Open.");
   a_abort_out: assert property (state_r == ST_EVAL && retry_cond && retries_r >= retry_lim_r |=> result_r == moist_pkg::RES_ABORT && st_r[moist_pkg::IRQ_ABORT])
      else $error("Retries exhausted without Abort.");
   a_sample_count: assert property ($rose(state_r == ST_EVAL) |-> acc_cnt == n_samples)
      else $error("Reading averaged the wrong number of samples.");
   a_current_follow: assert property (wr_en && idx == moist_pkg::IDX_TARGET |=> pullup_sel_o == $past(pwdata_i[1:0]))
      else $error("Pull-up select did not follow the write.");
   a_moist_thresh: assert property (state_r == ST_EVAL && !clip_w && avg_w > {4'h0, gnd_r} && avg_w < thresh_r |=> result_r == moist_pkg::RES_MOIST)
      else $error("Reading below threshold not classed moist.");
   a_forced_avg: assert property (done_w |=> (result_r == moist_pkg::RES_OPEN) ? final_avg_r == 8'hff : ((result_r == moist_pkg::RES_ABORT || result_r == moist_pkg::RES_GROUND) -> final_avg_r == 8'h00))
      else $error("Final average not forced for the result.");
   a_manual_clear: assert property (done_w && !wr_en |=> !manual_r ##1 state_r == ST_IDLE)
      else $error("Manual request not cleared at the end.");
   a_ground_class: assert property (state_r == ST_EVAL && !clip_w && avg_w <= {4'h0, gnd_r} |=> result_r == moist_pkg::RES_GROUND)
      else $error("Reading at ground threshold not classed Ground.");
endmodule

`default_nettype wire

// ---- include/moist_pkg.sv ----
// Purpose: Shared constants and types of the moisture measurement controller.
// Assumes: APB with 32-bit data; register index times four is the byte address.
// Notes: Contract

package moist_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W = 10;
   // Register indexes; the byte address is four times the index.
   localparam logic [9:0] IDX_GND_RETRY = 10'h070;
   localparam logic [9:0] IDX_SHIFT = 10'h071;
   localparam logic [9:0] IDX_AVG_CODE = 10'h072;
   localparam logic [9:0] IDX_NOISE = 10'h073;
   localparam logic [9:0] IDX_TARGET = 10'h074;
   localparam logic [9:0] IDX_THRESH = 10'h075;
   localparam logic [9:0] IDX_MANUAL = 10'h076;
   localparam logic [9:0] IDX_FINAL_AVG = 10'h078;
   localparam logic [9:0] IDX_RESULT = 10'h07c;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h07d;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h07e;
   // Field positions.
   localparam int unsigned GND_LSB = 3;
   localparam int unsigned MANUAL_BIT = 4;
   localparam int unsigned BUSY_BIT = 3;
   // Values after reset.
   localparam logic [3:0] RST_GROUND = 4'h4;
   localparam logic [2:0] RST_RETRY = 3'h1;
   localparam logic [5:0] RST_SHIFT = 6'h09;
   localparam logic [2:0] RST_AVG_CODE = 3'h0;
   localparam logic [5:0] RST_NOISE = 6'h00;
   localparam logic [1:0] RST_TARGET = 2'h0;
   localparam logic [7:0] RST_THRESH = 8'h77;
   // Reading limits and the lowest pull-up current code.
   localparam logic [7:0] FULL_SCALE = 8'hff;
   localparam logic [7:0] ZERO_SCALE = 8'h00;
   localparam logic [1:0] CUR_LOWEST = 2'h0;
   // Interrupt status bits.
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_MOIST = 1;
   localparam int unsigned IRQ_ABORT = 2;

   typedef enum logic [2:0]
   {
      RES_NONE = 3'b000,
      RES_DRY = 3'b001,
      RES_MOIST = 3'b010,
      RES_GROUND = 3'b011,
      RES_OPEN = 3'b100,
      RES_ABORT = 3'b101
   } result_t;
endpackage

// ---- design/sample_accumulator.sv ----
// Purpose: Sums ADC samples, tracks the largest and counts them.
// Assumes: Samples arrive on the system clock, one per valid pulse.
// Notes: Clear has priority over a sample in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module sample_accumulator #(
   parameter int unsigned DATA_W = 8,
   parameter int unsigned CNT_W = 8,
   parameter int unsigned SUM_W = 15
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic valid_i,
   input wire logic [DATA_W-1:0] data_i,
   output logic [SUM_W-1:0] sum_o,
   output logic [DATA_W-1:0] max_o,
   output logic [CNT_W-1:0] count_o
);
   logic [SUM_W-1:0] sum_r, sum_nxt;
   logic [DATA_W-1:0] max_r, max_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   // Sum width covers 128 full-scale samples, so the total never wraps.
   always_comb
   begin
      sum_nxt = sum_r;
      max_nxt = max_r;
      cnt_nxt = cnt_r;
      if (clear_i)
      begin
         sum_nxt = '0;
         max_nxt = '0;
         cnt_nxt = '0;
      end
      else if (valid_i)
      begin
         sum_nxt = sum_r + SUM_W'(data_i);
         cnt_nxt = cnt_r + CNT_W'(1);
         if (data_i > max_r)
         begin
            max_nxt = data_i;
         end
      end
   end

   // Registers only.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sum_r <= '0;
         max_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         sum_r <= sum_nxt;
         max_r <= max_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign sum_o = sum_r;
   assign max_o = max_r;
   assign count_o = cnt_r;
endmodule

`default_nettype wire

// ---- verif/adc_front_model.sv ----
// Purpose: Behavioural model of the pull-up source and measurement ADC.
// Assumes: One sample is answered per request, after a settable delay.
// Notes: The bench loads the sample queue and reads the request count.
`timescale 1ns/1ps
`default_nettype none

module adc_front_model (
   input wire logic clk_i,
   input wire logic sample_req_i,
   output logic adc_valid_o,
   output logic [7:0] adc_data_o
);
   logic [7:0] samples[$];
   logic [7:0] last_v = 8'h00;
   int delay = 0;
   int wait_cnt = -1;
   int n_req = 0;

   // Outputs start quiet so the block sees no sample before a request.
   initial
   begin
      adc_valid_o = 1'b0;
      adc_data_o = 8'h00;
   end

   // ------------------------------------------------------------
   // Request handling
   // ------------------------------------------------------------
   // Between answers the data lines carry the inverse of the last sample,
   // so a block that reads outside the valid pulse sees a wrong value.
   // Acting on the falling edge keeps the model clear of the edge on which the
   // block launches its request, so the request is never read mid-update.
   always @(negedge clk_i)
   begin
      adc_valid_o <= 1'b0;
      adc_data_o <= ~last_v;
      if (sample_req_i === 1'b1)
      begin
         n_req = n_req + 1;
         wait_cnt = delay;
      end
      if (wait_cnt == 0)
      begin
         last_v = (samples.size() > 0) ? samples.pop_front() : 8'h00;
         adc_valid_o <= 1'b1;
         adc_data_o <= last_v;
      end
      if (wait_cnt >= 0)
         wait_cnt = wait_cnt - 1;
   end
endmodule

`default_nettype wire

// ---- verif/test_moisture_adc_measure_ctrl.sv ----
// Purpose: Self-checking bench of the moisture measurement controller.
// Assumes: APB master waits for pready; ADC model answers each request.
// Notes: Noise margin is never written and shift only raised.
`timescale 1ns/1ps
`default_nettype none

module test_moisture_adc_measure_ctrl;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic adc_valid;
   logic [7:0] adc_data;
   logic sample_req;
   logic [1:0] pullup_sel;
   logic [5:0] shift_factor;
   logic irq;
   logic [31:0] rd_v;
   logic err_v;
   int n_fail = 0;
   int comparisons = 0;

   // The clock toggles every half period of 12.5 ns.
   always #12.5 clk = ~clk;

   moist_measure_ctrl i_dut (.clk_sys_i(clk), .nrst_i(nrst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .adc_valid_i(adc_valid), .adc_data_i(adc_data), .sample_req_o(sample_req),
      .pullup_sel_o(pullup_sel), .shift_factor_o(shift_factor), .irq_o(irq));

   adc_front_model i_adc (.clk_i(clk), .sample_req_i(sample_req),
      .adc_valid_o(adc_valid), .adc_data_o(adc_data));

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [11:0] ad(input logic [9:0] idx);
      return {idx, 2'b00};
   endfunction

   // One APB transfer; a release edge follows so the next call never
   // drives psel twice in one time step.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // The ready level is looked at mid-cycle, clear of the edge that launches it,
      // and the request is held through the following rising edge, where it is taken.
      do
      begin
         @(negedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      @(posedge clk);
      rd_v = prdata;
      err_v = pslverr;
      if (pready !== 1'b1)
         check(32'(pready), 32'h1, "pready timeout");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'b1, ad(idx), d);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, ad(idx), 32'h0);
      check(rd_v, exp, what);
      check(32'(err_v), 32'h0, "slave error");
   endtask

   task automatic settle();
      repeat (2) @(posedge clk);
   endtask

   // Runs one manual measurement and judges outcome, count and average.
   task automatic measure(input logic [1:0] cur, input logic [2:0] rty, input logic [2:0] code,
                          input int nreq, input moist_pkg::result_t res, input logic [7:0] avg);
      int n;
      wr(moist_pkg::IDX_TARGET, {30'h0, cur});
      wr(moist_pkg::IDX_GND_RETRY, {25'h0, 4'h4, rty});
      wr(moist_pkg::IDX_AVG_CODE, {29'h0, code});
      i_adc.n_req = 0;
      wr(moist_pkg::IDX_MANUAL, 32'h10);
      n = 0;
      do
      begin
         apb(1'b0, ad(moist_pkg::IDX_MANUAL), 32'h0);
         n++;
      end
      while (rd_v[4] !== 1'b0 && n < 200);
      check(32'(rd_v[4]), 32'h0, "manual bit clear");
      check(32'(i_adc.n_req), 32'(nreq), "sample requests");
      check(32'(pullup_sel), 32'(cur), "pull-up select");
      rd(moist_pkg::IDX_RESULT, 32'(res), "result");
      rd(moist_pkg::IDX_FINAL_AVG, {24'h0, avg}, "final average");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [9:0] idx[6];
      logic [31:0] exp[6];
      idx = '{moist_pkg::IDX_GND_RETRY, moist_pkg::IDX_SHIFT, moist_pkg::IDX_AVG_CODE,
              moist_pkg::IDX_NOISE, moist_pkg::IDX_TARGET, moist_pkg::IDX_THRESH};
      exp = '{32'h21, 32'h09, 32'h00, 32'h00, 32'h00, 32'h77};
      for (int i = 0; i < 6; i++)
         rd(idx[i], exp[i], "reset value");
      check(32'(shift_factor), 32'h09, "shift output");
      check(32'(irq), 32'h0, "irq after reset");
      apb(1'b0, ad(10'h077), 32'h0);
      check({rd_v[30:0], err_v}, 32'h1, "unmapped read");
      apb(1'b1, 12'h1c6, 32'h3f);
      check(32'(err_v), 32'h1, "unaligned write");
      rd(moist_pkg::IDX_SHIFT, 32'h09, "shift kept");
      $display("t_reset done");
   endtask

   task automatic t_config();
      for (int c = 0; c < 4; c++)
      begin
         wr(moist_pkg::IDX_TARGET, 32'(c));
         settle();
         check(32'(pullup_sel), 32'(c), "pull-up select");
         rd(moist_pkg::IDX_TARGET, 32'(c), "target readback");
      end
      // The shift factor is only ever raised above its default.
      wr(moist_pkg::IDX_SHIFT, 32'h0c);
      settle();
      check(32'(shift_factor), 32'h0c, "shift output");
      wr(moist_pkg::IDX_THRESH, 32'hc3);
      rd(moist_pkg::IDX_THRESH, 32'hc3, "threshold readback");
      wr(moist_pkg::IDX_THRESH, 32'h77);
      wr(moist_pkg::IDX_AVG_CODE, 32'h7);
      rd(moist_pkg::IDX_AVG_CODE, 32'h7, "average code readback");
      $display("t_config done");
   endtask

   task automatic t_outcomes();
      i_adc.samples = '{8'h10, 8'h20, 8'h30, 8'h40};
      measure(2'h1, 3'h1, 3'h2, 4, moist_pkg::RES_MOIST, 8'h28);
      i_adc.samples = '{8'h77};
      measure(2'h2, 3'h1, 3'h0, 1, moist_pkg::RES_DRY, 8'h77);
      i_adc.samples = '{8'h04};
      measure(2'h3, 3'h1, 3'h0, 1, moist_pkg::RES_GROUND, 8'h00);
      i_adc.samples = '{8'h05};
      measure(2'h3, 3'h1, 3'h0, 1, moist_pkg::RES_MOIST, 8'h05);
      i_adc.samples = '{8'hff};
      measure(2'h0, 3'h1, 3'h0, 1, moist_pkg::RES_OPEN, 8'hff);
      $display("t_outcomes done");
   endtask

   task automatic t_retry();
      i_adc.samples = '{8'hff, 8'h50};
      measure(2'h1, 3'h1, 3'h0, 2, moist_pkg::RES_MOIST, 8'h50);
      i_adc.delay = 5;
      i_adc.samples = '{8'hff, 8'hff, 8'hff};
      measure(2'h3, 3'h2, 3'h0, 3, moist_pkg::RES_ABORT, 8'h00);
      i_adc.delay = 0;
      i_adc.samples = '{8'hff};
      measure(2'h2, 3'h0, 3'h0, 1, moist_pkg::RES_ABORT, 8'h00);
      i_adc.samples = '{8'hff, 8'h01};
      measure(2'h0, 3'h0, 3'h1, 2, moist_pkg::RES_ABORT, 8'h00);
      $display("t_retry done");
   endtask

   task automatic t_irq();
      wr(moist_pkg::IDX_IRQ_MASK, 32'h0);
      wr(moist_pkg::IDX_IRQ_STATUS, 32'h7);
      i_adc.samples = '{8'h90};
      measure(2'h1, 3'h1, 3'h0, 1, moist_pkg::RES_DRY, 8'h90);
      settle();
      check(32'(irq), 32'h0, "irq masked");
      rd(moist_pkg::IDX_IRQ_STATUS, 32'h1, "done status");
      wr(moist_pkg::IDX_IRQ_MASK, 32'h1);
      settle();
      check(32'(irq), 32'h1, "irq unmasked");
      wr(moist_pkg::IDX_IRQ_STATUS, 32'h1);
      settle();
      check(32'(irq), 32'h0, "irq cleared");
      rd(moist_pkg::IDX_IRQ_STATUS, 32'h0, "status cleared");
      $display("t_irq done");
   endtask

   task automatic results();
      $display("Summary: %0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence: reset for six cycles, then the scenarios in order.
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_config();
      t_outcomes();
      t_retry();
      t_irq();
      results();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial
   begin
      #1000000;
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      results();
   end
endmodule

`default_nettype wire
